// *** design/bcs_defs.vh ***
// constants for the battery charger sequencer: register offsets, fields, resets, timing
// assumes the register port of the charger top uses 8-bit addresses and data
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH
// register offsets
`define BCS_ADDR_SUB_INT_MASK1 8'h05
`define BCS_ADDR_CHG_CTRL0 8'h10
`define BCS_ADDR_CHG_CTRL1 8'h11
`define BCS_ADDR_CHG_CTRL2 8'h12
`define BCS_ADDR_CHG_CTRL4 8'h14
`define BCS_ADDR_CHG_CTRL7 8'h17
`define BCS_ADDR_CHG_STATUS 8'h18
`define BCS_ADDR_LDO_AON 8'h19
`define BCS_ADDR_LDO_SYS 8'h1A
`define BCS_ADDR_SW_RESET 8'h1B
`define BCS_ADDR_RESET_MON 8'h71
// field positions
`define BCS_DEAD_MASK_BIT 6
`define BCS_DEAD_TMR_HI 7
`define BCS_DEAD_TMR_LO 6
`define BCS_TOPOFF_TMR_HI 1
`define BCS_TOPOFF_TMR_LO 0
`define BCS_LOCK_HI 4
`define BCS_LOCK_LO 0
`define BCS_CHG_EN_BIT 7
`define BCS_SYS_RANGE_BIT 7
// values
`define BCS_LOCK_KEY 5'h15
`define BCS_RST_MASK1 8'hFF
`define BCS_RST_CTRL0 8'h80
`define BCS_RST_CTRL1 8'h0A
`define BCS_RST_CTRL2 8'h28
`define BCS_RST_CTRL4 8'h00
`define BCS_RST_CTRL7 8'h03
`define BCS_RST_LDO_AON 8'h04
`define BCS_RST_LDO_SYS 8'h0C
`define BCS_AON_CODE_MAX 4'h8
`define BCS_SYS_CODE_MAX 5'h18
`define BCS_THERM_CODE_MAX 3'h6
`define BCS_MIN_CURRENT 6'h00
// timing: dead timer 5 s base doubling per code step, top-off 10 s per step, clock 100 ns
`define BCS_CLK_NS 100
`define BCS_DEAD_STEP_S 5
`define BCS_TOPOFF_STEP_S 10
`define BCS_DET_SETTLE_CYC 32'h0000000A
`endif

// *** design/bcs_sync3.v ***
// three-flop synchroniser with agreement filter for comparator levels
// assumes a single clock; the output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module bcs_sync3 #(
    parameter W = 1
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;
genvar g;
// per-bit capture chain and agreement filter
generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
        always @(posedge clk_i) begin
            if (sys_rst_i) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
                s3_q[g] <= 1'b0;
                sync_o[g] <= 1'b0;
            end else begin
                s1_q[g] <= async_i[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (s2_q[g] == s3_q[g]) begin
                    sync_o[g] <= s3_q[g];
                end
            end
        end
    end
endgenerate
endmodule // bcs_sync3
`default_nettype wire

// *** design/bcs_charger.v ***
// battery charger sequencer: detection, dead/pre/fast charge, top-off, regulator settings
// assumes analog comparators on pins, a register port driven by the serial slave, one clock
// Function
// - always-on regulator code spans 1.7 V to 1.9 V, 25 mV per code.
// - soft reset keeps always-on regulator on, settings return to defaults.
// - watchdog reset keeps always-on regulator on, takes mode 0 settings.
// - ship mode or long-press reset turns it off, then back on at default.
// - system regulator code covers 1.5-2.1 V and 2.7-3.3 V, 25 mV steps.
// - below low-battery threshold, precondition with programmed pre-charge current.
// - at low-battery threshold, fast charge with programmed constant current.
// - thermal threshold 85 to 115 C in 5 C steps sets regulation flag.
// - thermal regulation in constant current doubles timer, halves current except 5 mA.
// - thermal regulation in constant voltage uses reduced voltage target.
// - locked charger registers accept writes only while lock field holds 10101.
// - initial stage sources dead current; above 1.9 V goes straight to pre-charge, or to fast charge at low-battery threshold.
// - below 1.9 V dead timer runs 5 to 40 s; expiry means shorted battery.
// - masked dead-timer interrupt: charger continues to next stage after expiry.
// - unmasked dead-timer interrupt: raise interrupt and disable charger.
// - detection sinks 5 mA; staying above 1.9 V means battery present.
// - otherwise sources 5 mA; below 3.4 V means battery present.
// - above 3.4 V while sourcing means battery absent, charger stays off.
// - dead current and pre-charge current come from separate 6-bit fields.
// - pre-charge starts only after detection and below low-battery threshold.
// - pre-charge advances to fast charge once low threshold reached.
// - below top-off current enter top-off; top-off timer expiry enters done.
`timescale 1ns/1ns
`default_nettype none
`include "bcs_defs.vh"
module bcs_charger #(
    parameter DEAD_STEP_CYC = `BCS_DEAD_STEP_S * (1000000000 / `BCS_CLK_NS),
    parameter TOPOFF_STEP_CYC = `BCS_TOPOFF_STEP_S * (1000000000 / `BCS_CLK_NS)
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    input wire soft_reset_bit_i,
    input wire watchdog_reset_i,
    input wire ship_or_hw_reset_i,
    input wire [3:0] aon_mode0_code_i,
    input wire cmp_above_det_lower_i,
    input wire cmp_above_det_upper_i,
    input wire cmp_above_vbat_low_i,
    input wire cmp_at_vbat_reg_i,
    input wire cmp_below_topoff_i,
    input wire [2:0] cmp_die_temp_code_i,
    output reg always_on_regulator_en_o,
    output reg [3:0] always_on_regulator_code_o,
    output reg [4:0] system_regulator_code_o,
    output reg system_regulator_high_range_o,
    output reg det_sink_en_o,
    output reg det_source_en_o,
    output reg charge_en_o,
    output reg [5:0] charge_current_o,
    output reg reduced_vreg_o,
    output reg safety_timer_double_o,
    output reg battery_present_o,
    output reg battery_short_o,
    output reg dead_timeout_irq_o
);
// states
localparam S_DET_SINK = 9'h001;
localparam S_DET_SRC = 9'h002;
localparam S_DEAD = 9'h004;
localparam S_PRE = 9'h008;
localparam S_CC = 9'h010;
localparam S_CV = 9'h020;
localparam S_TOPOFF = 9'h040;
localparam S_DONE = 9'h080;
localparam S_OFF = 9'h100;
localparam [31:0] DEAD_STEP = DEAD_STEP_CYC;
localparam [31:0] TOPOFF_STEP = TOPOFF_STEP_CYC;

reg [7:0] mask1_q;
reg [7:0] ctrl0_q;
reg [7:0] ctrl1_q; // precharge_current in [5:0]
reg [7:0] ctrl2_q; // fast_charge_current in [5:0]
reg [7:0] ctrl3_q; // dead_current_setting in [5:0]
reg [7:0] ctrl4_q;
reg [7:0] ctrl7_q;
reg [7:0] ldo_aon_q;
reg [7:0] ldo_sys_q;
reg [7:0] rst_mon_q;
reg [8:0] state_q;
reg [31:0] tmr_q;
reg thermal_q;
reg aon_cycle_q;
reg [5:0] cur_sel;
wire unlocked;
wire [4:0] cmp_sync;
wire [2:0] temp_sync;
wire [31:0] dead_limit;
wire [31:0] topoff_limit;
wire seq_clear;
wire dead_irq_now;

////////////////////////////////////////////////////////////////////////////////
// comparator synchronisers
bcs_sync3 #(.W(5)) u_sync_cmp (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({cmp_above_det_lower_i, cmp_above_det_upper_i, cmp_above_vbat_low_i,
              cmp_at_vbat_reg_i, cmp_below_topoff_i}),
    .sync_o(cmp_sync)
);
bcs_sync3 #(.W(3)) u_sync_temp (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(cmp_die_temp_code_i),
    .sync_o(temp_sync)
);

////////////////////////////////////////////////////////////////////////////////
// register file
assign unlocked = (ctrl0_q[`BCS_LOCK_HI:`BCS_LOCK_LO] == `BCS_LOCK_KEY);
// dead timer code 0..3 selects 5,10,20,40 s; top-off code selects 10..40 s
assign dead_limit = DEAD_STEP << ctrl4_q[`BCS_DEAD_TMR_HI:`BCS_DEAD_TMR_LO];
assign topoff_limit = TOPOFF_STEP * ({30'h0, ctrl4_q[`BCS_TOPOFF_TMR_HI:`BCS_TOPOFF_TMR_LO]}
    + 32'h1);
// charger stops in the very cycle that the sequencer is cleared or trips the dead interrupt
assign seq_clear = soft_reset_bit_i || !ctrl0_q[`BCS_CHG_EN_BIT];
assign dead_irq_now = (state_q == S_DEAD) && !cmp_sync[4] && (tmr_q >= dead_limit - 32'h1)
    && !mask1_q[`BCS_DEAD_MASK_BIT];

// register writes, soft and regulator resets
always @(posedge clk_i) begin
    if (sys_rst_i || soft_reset_bit_i) begin
        mask1_q <= `BCS_RST_MASK1;
        ctrl0_q <= `BCS_RST_CTRL0;
        ctrl1_q <= `BCS_RST_CTRL1;
        ctrl2_q <= `BCS_RST_CTRL2;
        ctrl3_q <= `BCS_RST_CTRL1;
        ctrl4_q <= `BCS_RST_CTRL4;
        ctrl7_q <= `BCS_RST_CTRL7;
        ldo_aon_q <= `BCS_RST_LDO_AON;
        ldo_sys_q <= `BCS_RST_LDO_SYS;
    end else if (ship_or_hw_reset_i) begin
        ldo_aon_q <= `BCS_RST_LDO_AON;
    end else if (watchdog_reset_i) begin
        ldo_aon_q <= {4'h0, aon_mode0_code_i};
    end else if (reg_wr_i) begin
        if (reg_addr_i == `BCS_ADDR_SUB_INT_MASK1) begin
            mask1_q <= reg_wdata_i;
        end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL0) begin
            ctrl0_q <= reg_wdata_i; // lock field itself is always writable
        end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL1 && unlocked) begin
            ctrl1_q <= reg_wdata_i;
        end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL2 && unlocked) begin
            ctrl2_q <= reg_wdata_i;
        end else if (reg_addr_i == `BCS_ADDR_CHG_STATUS && unlocked) begin
            ctrl3_q <= reg_wdata_i;
        end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL4 && unlocked) begin
            ctrl4_q <= reg_wdata_i;
        end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL7 && unlocked) begin
            ctrl7_q <= reg_wdata_i;
        end else if (reg_addr_i == `BCS_ADDR_LDO_AON) begin
            if (reg_wdata_i[3:0] <= `BCS_AON_CODE_MAX) begin
                ldo_aon_q <= reg_wdata_i;
            end
        end else if (reg_addr_i == `BCS_ADDR_LDO_SYS) begin
            if (reg_wdata_i[4:0] <= `BCS_SYS_CODE_MAX) begin
                ldo_sys_q <= reg_wdata_i;
            end
        end
    end
end

// reset source monitor: sticky record, cleared by software reset
always @(posedge clk_i) begin
    if (sys_rst_i || soft_reset_bit_i) begin
        rst_mon_q <= 8'h00;
    end else begin
        rst_mon_q <= rst_mon_q | {6'h0, ship_or_hw_reset_i, watchdog_reset_i};
    end
end

// read mux
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == `BCS_ADDR_SUB_INT_MASK1) begin
        reg_rdata_o <= mask1_q;
    end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL0) begin
        reg_rdata_o <= ctrl0_q;
    end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL1) begin
        reg_rdata_o <= ctrl1_q;
    end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL2) begin
        reg_rdata_o <= ctrl2_q;
    end else if (reg_addr_i == `BCS_ADDR_CHG_STATUS) begin
        reg_rdata_o <= {thermal_q, state_q[6:0]};
    end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL4) begin
        reg_rdata_o <= ctrl4_q;
    end else if (reg_addr_i == `BCS_ADDR_CHG_CTRL7) begin
        reg_rdata_o <= ctrl7_q;
    end else if (reg_addr_i == `BCS_ADDR_LDO_AON) begin
        reg_rdata_o <= ldo_aon_q;
    end else if (reg_addr_i == `BCS_ADDR_LDO_SYS) begin
        reg_rdata_o <= ldo_sys_q;
    end else if (reg_addr_i == `BCS_ADDR_SW_RESET) begin
        reg_rdata_o <= ctrl3_q;
    end else if (reg_addr_i == `BCS_ADDR_RESET_MON) begin
        reg_rdata_o <= rst_mon_q;
    end else begin
        reg_rdata_o <= 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// charger sequencer
always @(posedge clk_i) begin
    if (sys_rst_i || soft_reset_bit_i || !ctrl0_q[`BCS_CHG_EN_BIT]) begin
        state_q <= S_DET_SINK;
        tmr_q <= 32'h0;
        battery_present_o <= 1'b0;
        battery_short_o <= 1'b0;
        dead_timeout_irq_o <= 1'b0;
    end else begin
        case (state_q)
            S_DET_SINK: begin
                tmr_q <= tmr_q + 32'h1; // sink current and synchroniser settle
                if (tmr_q >= `BCS_DET_SETTLE_CYC - 32'h1) begin
                    tmr_q <= 32'h0;
                    if (cmp_sync[4]) begin
                        battery_present_o <= 1'b1;
                        state_q <= S_DEAD;
                    end else begin
                        state_q <= S_DET_SRC;
                    end
                end
            end
            S_DET_SRC: begin
                tmr_q <= tmr_q + 32'h1; // source current and synchroniser settle
                if (tmr_q >= `BCS_DET_SETTLE_CYC - 32'h1) begin
                    tmr_q <= 32'h0;
                    if (!cmp_sync[3]) begin
                        battery_present_o <= 1'b1;
                        state_q <= S_DEAD;
                    end else begin
                        state_q <= S_OFF;
                    end
                end
            end
            S_DEAD: begin
                if (cmp_sync[4]) begin
                    tmr_q <= 32'h0;
                    state_q <= cmp_sync[2] ? S_CC : S_PRE;
                end else if (tmr_q >= dead_limit - 32'h1) begin
                    tmr_q <= 32'h0;
                    battery_short_o <= 1'b1;
                    if (mask1_q[`BCS_DEAD_MASK_BIT]) begin
                        state_q <= S_PRE;
                    end else begin
                        dead_timeout_irq_o <= 1'b1;
                        state_q <= S_OFF;
                    end
                end else begin
                    tmr_q <= tmr_q + 32'h1;
                end
            end
            S_PRE: begin
                if (cmp_sync[2]) begin
                    state_q <= S_CC;
                end
            end
            S_CC: begin
                if (cmp_sync[1]) begin
                    state_q <= S_CV;
                end
            end
            S_CV: begin
                if (cmp_sync[0]) begin
                    tmr_q <= 32'h0;
                    state_q <= S_TOPOFF;
                end
            end
            S_TOPOFF: begin
                if (tmr_q >= topoff_limit - 32'h1) begin
                    state_q <= S_DONE;
                end else begin
                    tmr_q <= tmr_q + 32'h1;
                end
            end
            S_DONE: begin
                state_q <= S_DONE;
            end
            default: begin
                state_q <= S_OFF;
            end
        endcase
    end
end

// thermal regulation flag from die temperature code vs limit select
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        thermal_q <= 1'b0;
    end else begin
        thermal_q <= (temp_sync >= ctrl7_q[2:0]);
    end
end

// current select per stage
always @* begin
    cur_sel = 6'h00;
    if (state_q == S_DEAD) begin
        cur_sel = ctrl3_q[5:0];
    end else if (state_q == S_PRE) begin
        cur_sel = ctrl1_q[5:0];
    end else if (state_q == S_CC || state_q == S_CV || state_q == S_TOPOFF) begin
        cur_sel = ctrl2_q[5:0];
    end
end

// analog drive outputs
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        det_sink_en_o <= 1'b0;
        det_source_en_o <= 1'b0;
        charge_en_o <= 1'b0;
        charge_current_o <= 6'h00;
        reduced_vreg_o <= 1'b0;
        safety_timer_double_o <= 1'b0;
    end else begin
        det_sink_en_o <= (state_q == S_DET_SINK);
        det_source_en_o <= (state_q == S_DET_SRC);
        charge_en_o <= |(state_q & (S_DEAD | S_PRE | S_CC | S_CV | S_TOPOFF)) && !seq_clear
            && !dead_irq_now;
        if (thermal_q && state_q == S_CC && cur_sel != `BCS_MIN_CURRENT) begin
            charge_current_o <= {1'b0, cur_sel[5:1]};
        end else begin
            charge_current_o <= cur_sel;
        end
        safety_timer_double_o <= thermal_q && state_q == S_CC;
        reduced_vreg_o <= thermal_q && state_q == S_CV;
    end
end

////////////////////////////////////////////////////////////////////////////////
// regulator outputs: always-on stays on except off while ship/long press is high and one cycle after
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        aon_cycle_q <= 1'b0;
        always_on_regulator_en_o <= 1'b1;
        always_on_regulator_code_o <= 4'h4;
        system_regulator_code_o <= 5'h0C;
        system_regulator_high_range_o <= 1'b0;
    end else begin
        aon_cycle_q <= ship_or_hw_reset_i;
        always_on_regulator_en_o <= !(ship_or_hw_reset_i || aon_cycle_q);
        always_on_regulator_code_o <= ldo_aon_q[3:0];
        system_regulator_code_o <= ldo_sys_q[4:0];
        system_regulator_high_range_o <= ldo_sys_q[`BCS_SYS_RANGE_BIT];
    end
end

endmodule // bcs_charger
`default_nettype wire

// *** verif/bcs_charger_monitor.sv ***
// checker for the charger sequencer top ports
// assumes one clock clk_i and the synchronous active-high reset sys_rst_i
`timescale 1ns/1ns
`default_nettype none
module bcs_charger_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic soft_reset_bit_i,
    input wire logic watchdog_reset_i,
    input wire logic ship_or_hw_reset_i,
    input wire logic [3:0] aon_mode0_code_i,
    input wire logic always_on_regulator_en_o,
    input wire logic [3:0] always_on_regulator_code_o,
    input wire logic [4:0] system_regulator_code_o,
    input wire logic det_sink_en_o,
    input wire logic det_source_en_o,
    input wire logic charge_en_o,
    input wire logic battery_present_o,
    input wire logic battery_short_o,
    input wire logic dead_timeout_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // regulator back on at its default code, and the off-then-on recycle
    sequence s_aon_default;
        always_on_regulator_en_o && always_on_regulator_code_o == 4'h4;
    endsequence
    sequence s_off_then_default;
        !always_on_regulator_en_o ##[1:4] s_aon_default;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // regulator settings and reset reactions
    chk_aon_code_range: assert property (always_on_regulator_code_o <= 4'h8)
        else $error("always-on code out of range");
    chk_sys_code_range: assert property (system_regulator_code_o <= 5'h18)
        else $error("system code out of range");
    chk_soft_keeps_on: assert property (soft_reset_bit_i && !ship_or_hw_reset_i |-> ##2 s_aon_default)
        else $error("soft reset lost regulator default");
    chk_wdog_mode_zero: assert property (watchdog_reset_i && !soft_reset_bit_i && !ship_or_hw_reset_i
        |-> ##2 always_on_regulator_en_o && always_on_regulator_code_o == $past(aon_mode0_code_i, 2))
        else $error("watchdog did not apply mode zero code");
    chk_ship_recycle: assert property ($rose(ship_or_hw_reset_i) |=> s_off_then_default)
        else $error("ship reset did not recycle regulator");
    ////////////////////////////////////////////////////////////////////////////////
    // detection and charge enables
    chk_sink_src_excl: assert property (!(det_sink_en_o && det_source_en_o))
        else $error("sink and source both on");
    chk_charge_needs_batt: assert property (charge_en_o |-> battery_present_o)
        else $error("charging without a battery");
    chk_irq_stops_chg: assert property (dead_timeout_irq_o |-> !charge_en_o)
        else $error("charger on with dead timeout flag");
    chk_irq_with_short: assert property ($rose(dead_timeout_irq_o) |-> battery_short_o)
        else $error("dead timeout flag without short");
endmodule // bcs_charger_monitor
bind bcs_charger bcs_charger_monitor i_bcs_charger_monitor (
    .clk_i, .sys_rst_i, .soft_reset_bit_i, .watchdog_reset_i, .ship_or_hw_reset_i,
    .aon_mode0_code_i, .always_on_regulator_en_o, .always_on_regulator_code_o,
    .system_regulator_code_o, .det_sink_en_o, .det_source_en_o, .charge_en_o,
    .battery_present_o, .battery_short_o, .dead_timeout_irq_o
);
`default_nettype wire

// *** verif/bcs_batt_model.sv ***
// single-cell battery and analog comparator model facing the charger pins
// assumes the bench sets cell voltage, presence and die temperature code
`timescale 1ns/1ns
`default_nettype none
module bcs_batt_model #(
    parameter int LOW_MV = 3000,
    parameter int REG_MV = 4200,
    parameter int TAPER_CYC = 30
) (
    input wire logic clk_i,
    input wire logic [12:0] vbat_mv_i,
    input wire logic absent_i,
    input wire logic [2:0] temp_code_i,
    input wire logic det_sink_en_i,
    input wire logic det_source_en_i,
    input wire logic charge_en_i,
    output logic cmp_above_det_lower_o,
    output logic cmp_above_det_upper_o,
    output logic cmp_above_vbat_low_o,
    output logic cmp_at_vbat_reg_o,
    output logic cmp_below_topoff_o,
    output logic [2:0] cmp_die_temp_code_o
);
    logic [12:0] pin_mv = 13'h0000;
    int taper = 0;
    // open pin is pulled to ground by the sink and up by the source; current tapers in cv
    always @(posedge clk_i) begin
        if (!absent_i) pin_mv <= vbat_mv_i;
        else if (det_sink_en_i) pin_mv <= 13'h0000;
        else if (det_source_en_i) pin_mv <= 13'h1194;
        taper <= (charge_en_i && pin_mv >= REG_MV) ? taper + 1 : 0;
    end
    // comparator levels
    assign cmp_above_det_lower_o = pin_mv > 13'h076C;
    assign cmp_above_det_upper_o = pin_mv > 13'h0D48;
    assign cmp_above_vbat_low_o = pin_mv >= LOW_MV;
    assign cmp_at_vbat_reg_o = pin_mv >= REG_MV;
    assign cmp_below_topoff_o = taper >= TAPER_CYC;
    assign cmp_die_temp_code_o = temp_code_i;
endmodule // bcs_batt_model
`default_nettype wire

// *** verif/tb_top.sv ***
// testbench for the charger sequencer: register tasks and charge flow scenarios
// assumes the battery model drives the comparators and the checker is bound
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
`define WAITC(c) for (k = 0; k < 400 && !(c); k++) begin @(posedge clk_i); #1; end
module tb_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic soft_reset_bit_i = 1'b0, watchdog_reset_i = 1'b0, ship_or_hw_reset_i = 1'b0;
    logic [3:0] aon_mode0_code_i = 4'h2;
    logic [12:0] vbat_mv = 13'h09C4;
    logic absent = 1'b0;
    logic [2:0] temp_code = 3'h0;
    wire cmp_above_det_lower_i, cmp_above_det_upper_i, cmp_above_vbat_low_i;
    wire cmp_at_vbat_reg_i, cmp_below_topoff_i;
    wire [2:0] cmp_die_temp_code_i;
    wire [7:0] reg_rdata_o;
    wire [3:0] always_on_regulator_code_o;
    wire [4:0] system_regulator_code_o;
    wire [5:0] charge_current_o;
    wire always_on_regulator_en_o, system_regulator_high_range_o, det_sink_en_o;
    wire det_source_en_o, charge_en_o, reduced_vreg_o, safety_timer_double_o;
    wire battery_present_o, battery_short_o, dead_timeout_irq_o;
    int num_errors = 0;
    int total_checks = 0;
    int k;
    ////////////////////////////////////////////////////////////////////////////////
    // design with short dead and top-off steps, and the battery model
    bcs_charger #(.DEAD_STEP_CYC(20), .TOPOFF_STEP_CYC(10)) i_bcs_charger (
        .clk_i, .sys_rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .soft_reset_bit_i, .watchdog_reset_i, .ship_or_hw_reset_i, .aon_mode0_code_i,
        .cmp_above_det_lower_i, .cmp_above_det_upper_i, .cmp_above_vbat_low_i,
        .cmp_at_vbat_reg_i, .cmp_below_topoff_i, .cmp_die_temp_code_i,
        .always_on_regulator_en_o, .always_on_regulator_code_o, .system_regulator_code_o,
        .system_regulator_high_range_o, .det_sink_en_o, .det_source_en_o, .charge_en_o,
        .charge_current_o, .reduced_vreg_o, .safety_timer_double_o, .battery_present_o,
        .battery_short_o, .dead_timeout_irq_o
    );
    bcs_batt_model i_bcs_batt_model (
        .clk_i, .vbat_mv_i(vbat_mv), .absent_i(absent), .temp_code_i(temp_code),
        .det_sink_en_i(det_sink_en_o), .det_source_en_i(det_source_en_o),
        .charge_en_i(charge_en_o), .cmp_above_det_lower_o(cmp_above_det_lower_i),
        .cmp_above_det_upper_o(cmp_above_det_upper_i), .cmp_above_vbat_low_o(cmp_above_vbat_low_i),
        .cmp_at_vbat_reg_o(cmp_at_vbat_reg_i), .cmp_below_topoff_o(cmp_below_topoff_i),
        .cmp_die_temp_code_o(cmp_die_temp_code_i)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // register access, pulses and verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        @(posedge clk_i);
        #1 d = reg_rdata_o;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] d;
        rd(a, d);
        `CHK("register", ex, d)
    endtask
    task automatic pulse(input int w);
        @(posedge clk_i);
        soft_reset_bit_i <= (w == 0);
        watchdog_reset_i <= (w == 1);
        ship_or_hw_reset_i <= (w == 2);
        @(posedge clk_i);
        {soft_reset_bit_i, watchdog_reset_i, ship_or_hw_reset_i} <= 3'h0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic restart;
        wr(8'h10, 8'h15);
        wr(8'h10, 8'h95);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // clock, and watchdog against a hung sequence
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #(30000 * 100);
        num_errors++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] d;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1 `CHK("aon_en", 1'b1, always_on_regulator_en_o)
        rc(8'h05, 8'hFF);
        rc(8'h10, 8'h80);
        rc(8'h14, 8'h00);
        rc(8'h17, 8'h03);
        rc(8'h19, 8'h04);
        rc(8'h1A, 8'h0C);
        rc(8'h30, 8'h00);
        wr(8'h12, 8'h20);
        rc(8'h12, 8'h28);
        wr(8'h10, 8'h15);
        wr(8'h12, 8'h20);
        rc(8'h12, 8'h20);
        wr(8'h19, 8'h07);
        wr(8'h19, 8'h09);
        rc(8'h19, 8'h07);
        `CHK("aon_code", 4'h7, always_on_regulator_code_o)
        wr(8'h1A, 8'h98);
        wr(8'h1A, 8'h19);
        rc(8'h1A, 8'h98);
        `CHK("sys_code", 5'h18, system_regulator_code_o)
        `CHK("sys_range", 1'b1, system_regulator_high_range_o)
        wr(8'h11, 8'h05);
        wr(8'h18, 8'h03);
        wr(8'h14, 8'h41);
        wr(8'h10, 8'h95);
        `WAITC(charge_current_o === 6'h05)
        `CHK("pre_cur", 6'h05, charge_current_o)
        `CHK("present", 1'b1, battery_present_o)
        @(posedge clk_i) vbat_mv <= 13'h0CE4;
        `WAITC(charge_current_o === 6'h20)
        `CHK("fast_cur", 6'h20, charge_current_o)
        @(posedge clk_i) temp_code <= 3'h3;
        `WAITC(safety_timer_double_o === 1'b1)
        repeat (2) @(posedge clk_i);
        #1 `CHK("half_cur", 6'h10, charge_current_o)
        rd(8'h18, d);
        `CHK("treg", 1'b1, d[7])
        @(posedge clk_i) vbat_mv <= 13'h1068;
        `WAITC(reduced_vreg_o === 1'b1)
        `CHK("cv_vreg", 1'b1, reduced_vreg_o)
        `WAITC(charge_en_o === 1'b0)
        `CHK("done", 1'b0, charge_en_o)
        @(posedge clk_i) vbat_mv <= 13'h03E8;
        temp_code <= 3'h0;
        restart();
        `WAITC(charge_current_o === 6'h03)
        `CHK("dead_cur", 6'h03, charge_current_o)
        `WAITC(battery_short_o === 1'b1)
        `CHK("dead_time", 1'b1, k > 35 && k < 45)
        `WAITC(charge_current_o === 6'h05)
        `CHK("masked_pre", 6'h05, charge_current_o)
        wr(8'h05, 8'hBF);
        restart();
        `WAITC(dead_timeout_irq_o === 1'b1)
        `CHK("irq", 1'b1, dead_timeout_irq_o)
        `CHK("irq_off", 1'b0, charge_en_o)
        @(posedge clk_i) absent <= 1'b1;
        restart();
        `WAITC(det_source_en_o === 1'b1)
        repeat (20) @(posedge clk_i);
        #1 `CHK("absent", 1'b0, battery_present_o)
        `CHK("absent_off", 1'b0, charge_en_o)
        @(posedge clk_i) absent <= 1'b0;
        pulse(1);
        `CHK("wd_en", 1'b1, always_on_regulator_en_o)
        `CHK("wd_code", 4'h2, always_on_regulator_code_o)
        rd(8'h71, d);
        `CHK("wd_mon", 1'b1, d[0])
        pulse(0);
        `CHK("sr_en", 1'b1, always_on_regulator_en_o)
        `CHK("sr_code", 4'h4, always_on_regulator_code_o)
        rc(8'h12, 8'h28);
        rc(8'h1A, 8'h0C);
        wr(8'h19, 8'h07);
        pulse(2);
        `CHK("ship_off", 1'b0, always_on_regulator_en_o)
        `WAITC(always_on_regulator_en_o === 1'b1)
        `CHK("ship_code", 4'h4, always_on_regulator_code_o)
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
